//--- pkg/uart_mlc_consts.vh
// register offsets, field positions, reset values for modem control and line status
`ifndef UART_MLC_CONSTS_VH
`define UART_MLC_CONSTS_VH
// ==========================================
// register offsets
`define OFS_MODEM_CONTROL   3'h4
`define OFS_LINE_STATUS     3'h5
// ==========================================
// reset values
`define RST_MODEM_CONTROL   8'h00
`define RST_LINE_STATUS     8'h60
// ==========================================
// modem control fields
`define MC_DTR              0
`define MC_RTS              1
`define MC_OUT_ONE          2
`define MC_OUT_TWO          3
`define MC_LOOPBACK         4
`define MC_ANY_RESUME       5
`define MC_LOCKED_MASK      8'he0
// ==========================================
// other fields
`define LC_DIVISOR_LATCH    7
`define EF_ENHANCED         4
`define AM_STATUS_BIT0      0
`define LS_FIFO_ERR         7
`define LS_TX_IDLE          6
`define LS_THR_EMPTY        5
// ==========================================
// modem status loopback bit positions
`define MS_CTS              4
`define MS_DSR              5
`define MS_RI               6
`define MS_CD               7
`endif

//--- verilog/uart_mlc_sync.v
// two-flop synchroniser for pin inputs, one instance per bit
module uart_mlc_sync #(
    parameter RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire clk_sys,
    input  wire resetn,
    input  wire clk_en,
    // data
    input  wire din,
    output reg  dout
);
    reg stage1_reg;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= RESET_VAL;
            dout       <= RESET_VAL;
        end else if (clk_en) begin
            stage1_reg <= din;
            dout       <= stage1_reg;
        end
    end
endmodule

//--- verilog/uart_modem_line_control.v
// modem control and upper line status registers of one uart channel
`include "uart_mlc_consts.vh"

module uart_modem_line_control (
    // clock, reset, enable
    input  wire       clk_sys,
    input  wire       resetn,
    input  wire       clk_en,
    // register port
    input  wire [2:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    // configuration from other registers of the core
    input  wire       line_control_dlab,
    input  wire       enhanced_feature_en,
    input  wire       auto_mode_status_bit0,
    input  wire       auto_rts_en,
    input  wire       auto_rts_level,
    input  wire       rx_sw_flow_en,
    // receiver and transmitter core status
    input  wire       rx_char_valid,
    input  wire       rx_char_is_flow,
    input  wire       rx_fifo_err_present,
    input  wire       thr_loaded,
    input  wire       thr_to_tsr,
    input  wire       tsr_busy,
    input  wire       tx_serial,
    input  wire       core_irq,
    // serial pins
    input  wire       serial_in,
    input  wire       cts_n_pin,
    input  wire       dsr_n_pin,
    input  wire       ri_n_pin,
    input  wire       cd_n_pin,
    input  wire       interrupt_select_pin,
    output reg        serial_out,
    output reg        rts_n,
    output reg        dtr_n,
    output reg        user_output_two_n,
    output reg        irq_out,
    output reg        irq_oe,
    // loopback and flow results to the core
    output reg        rx_serial,
    output reg  [3:0] modem_status_lines,
    output reg        tx_resume,
    output reg        rx_char_store,
    output reg        fifo_ready_status_rd_en,
    output reg        loopback_active
);
    // ==========================================
    // pin synchronisers
    wire [5:0] pins_raw;
    wire [5:0] pins_sync;
    assign pins_raw = {interrupt_select_pin, serial_in, cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            uart_mlc_sync #(
                .RESET_VAL (gi == 5 ? 1'b0 : 1'b1)
            ) u_sync (
                .clk_sys (clk_sys),
                .resetn  (resetn),
                .clk_en  (clk_en),
                .din     (pins_raw[gi]),
                .dout    (pins_sync[gi])
            );
        end
    endgenerate

    wire cts_n_s  = pins_sync[0];
    wire dsr_n_s  = pins_sync[1];
    wire ri_n_s   = pins_sync[2];
    wire cd_n_s   = pins_sync[3];
    wire sin_s    = pins_sync[4];
    wire interrupt_select_pin_s = pins_sync[5];

    // ==========================================
    // registers
    reg  [7:0] modem_control_reg;
    reg  [7:0] modem_control_next;
    reg        fifo_err_reg;
    reg        tx_idle_reg;
    reg        thr_empty_reg;
    reg        thr_empty_next;
    reg        tx_idle_next;

    // reset image of line status, so each flag resets from one constant
    localparam [7:0] LS_RESET = `RST_LINE_STATUS;

    wire regs_visible = ~line_control_dlab;
    wire mc_wr = reg_wr & regs_visible & (reg_addr == `OFS_MODEM_CONTROL);
    wire loop  = modem_control_reg[`MC_LOOPBACK];
    wire [7:0] line_status = {fifo_err_reg, tx_idle_reg, thr_empty_reg, 5'b0_0000};

    always @* begin
        modem_control_next = modem_control_reg;
        if (mc_wr) begin
            if (enhanced_feature_en) begin
                modem_control_next = reg_wdata;
            end else begin
                // upper bits guarded so a legacy driver cannot flip enhanced modes
                modem_control_next = (modem_control_reg & `MC_LOCKED_MASK) |
                                     (reg_wdata & ~`MC_LOCKED_MASK);
            end
        end
    end

    always @* begin
        // a load in the same cycle as the transfer means the holding reg refilled
        thr_empty_next = thr_empty_reg;
        if (thr_to_tsr) begin
            thr_empty_next = 1'b1;
        end
        if (thr_loaded) begin
            thr_empty_next = 1'b0;
        end
        tx_idle_next = thr_empty_next & ~tsr_busy & ~thr_loaded;
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            modem_control_reg <= `RST_MODEM_CONTROL;
            fifo_err_reg      <= LS_RESET[`LS_FIFO_ERR];
            tx_idle_reg       <= LS_RESET[`LS_TX_IDLE];
            thr_empty_reg     <= LS_RESET[`LS_THR_EMPTY];
        end else if (clk_en) begin
            modem_control_reg <= modem_control_next;
            fifo_err_reg      <= rx_fifo_err_present;
            tx_idle_reg       <= tx_idle_next;
            thr_empty_reg     <= thr_empty_next;
        end
    end

    // ==========================================
    // register read port
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd && regs_visible && reg_addr == `OFS_LINE_STATUS) begin
                reg_rdata <= line_status;
            end else if (reg_rd && regs_visible && reg_addr == `OFS_MODEM_CONTROL) begin
                reg_rdata <= modem_control_reg;
            end else if (reg_rd) begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ==========================================
    // pins, loopback and flow outputs
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serial_out              <= 1'b1;
            rts_n                   <= 1'b1;
            dtr_n                   <= 1'b1;
            user_output_two_n       <= 1'b1;
            irq_out                 <= 1'b0;
            irq_oe                  <= 1'b0;
            rx_serial               <= 1'b1;
            modem_status_lines      <= 4'h0;
            tx_resume               <= 1'b0;
            rx_char_store           <= 1'b0;
            fifo_ready_status_rd_en <= 1'b0;
            loopback_active         <= 1'b0;
        end else if (clk_en) begin
            loopback_active <= loop;
            // looped traffic kept off the line
            serial_out <= loop ? 1'b1 : tx_serial;
            rx_serial  <= loop ? tx_serial : sin_s;
            // pins go to the inactive level while looped, per classic uart behaviour
            rts_n <= loop ? 1'b1 :
                     (auto_rts_en ? ~auto_rts_level :
                      ~modem_control_reg[`MC_RTS]);
            dtr_n <= loop ? 1'b1 : ~modem_control_reg[`MC_DTR];
            user_output_two_n <= loop ? 1'b1 : ~modem_control_reg[`MC_OUT_TWO];
            // order: cts, dsr, ri, cd (modem status bits 4..7)
            if (loop) begin
                modem_status_lines <= {modem_control_reg[`MC_OUT_TWO],
                                       modem_control_reg[`MC_OUT_ONE],
                                       modem_control_reg[`MC_DTR],
                                       modem_control_reg[`MC_RTS]};
            end else begin
                modem_status_lines <= {~cd_n_s, ~ri_n_s, ~dsr_n_s, ~cts_n_s};
            end
            irq_out <= core_irq;
            irq_oe  <= interrupt_select_pin_s | modem_control_reg[`MC_OUT_TWO];
            tx_resume <= rx_char_valid & modem_control_reg[`MC_ANY_RESUME];
            rx_char_store <= rx_char_valid & ~(rx_char_is_flow & rx_sw_flow_en);
            fifo_ready_status_rd_en <= modem_control_reg[`MC_OUT_ONE] & ~loop &
                                       ~auto_mode_status_bit0;
        end
    end
endmodule

//--- sim/uart_mlc_props.sv
// concurrent checks on the modem control and line status block ports
module uart_mlc_props (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       resetn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       line_control_dlab,
    // core status
    input wire logic       rx_char_valid,
    input wire logic       rx_char_is_flow,
    input wire logic       rx_fifo_err_present,
    input wire logic       tx_serial,
    // pins and results
    input wire logic       interrupt_select_pin,
    input wire logic       serial_out,
    input wire logic       irq_oe,
    input wire logic       rx_serial,
    input wire logic       tx_resume,
    input wire logic       rx_char_store,
    input wire logic       loopback_active
);
timeunit 1ns;
timeprecision 1ns;
// ==========================================
default clocking @(posedge clk_sys); endclocking
default disable iff (!resetn);
a_read_valid: assert property (reg_rd && !line_control_dlab |=> reg_rvalid)
    else $error("read not answered");
a_latch_hides: assert property (reg_rd && line_control_dlab |=> reg_rdata == 8'h00)
    else $error("register visible under divisor latch");
a_loop_mark: assert property (loopback_active |-> serial_out)
    else $error("serial line not at mark in loopback");
a_loop_route: assert property (loopback_active ##1 loopback_active |-> rx_serial == $past(tx_serial))
    else $error("transmit not looped to receive");
a_resume_cause: assert property (!rx_char_valid |=> !tx_resume)
    else $error("resume without a character");
a_store_plain: assert property (rx_char_valid && !rx_char_is_flow |=> rx_char_store)
    else $error("plain character not stored");
a_select_force: assert property (interrupt_select_pin [*4] |-> irq_oe)
    else $error("select pin does not force interrupt drive");
// error summary must be visible once the level has settled through the register
a_err_summary: assert property (rx_fifo_err_present [*3] ##0 (reg_rd && reg_addr == 3'h5 && !line_control_dlab)
    |=> reg_rdata[7])
    else $error("fifo error summary missing");
endmodule
bind uart_modem_line_control uart_mlc_props u_uart_mlc_props (.*);

//--- sim/uart_mlc_far.sv
// far-side modem lines: pulled up, inactive, serial line resting at mark
module uart_mlc_far (
    // control from bench
    input wire logic int_sel,
    // modem pins
    output logic     serial_in,
    output logic     cts_n_pin,
    output logic     dsr_n_pin,
    output logic     ri_n_pin,
    output logic     cd_n_pin,
    output logic     interrupt_select_pin
);
timeunit 1ns;
timeprecision 1ns;
// ==========================================
assign serial_in = 1'b1;
assign {cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin} = 4'hf;
assign interrupt_select_pin = int_sel;
endmodule

//--- sim/uart_modem_line_control_test.sv
// self-checking bench for modem control and line status registers
module uart_modem_line_control_test;
timeunit 1ns;
timeprecision 1ns;
// ==========================================
logic clk_sys = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, int_sel = 0, core_irq = 0, tx_serial = 1;
logic [2:0] reg_addr = 3'h0;
logic [7:0] reg_wdata = 8'h00, reg_rdata;
logic line_control_dlab = 0, enhanced_feature_en = 0, auto_mode_status_bit0 = 0, auto_rts_en = 0, auto_rts_level = 0;
logic rx_sw_flow_en = 0, rx_char_valid = 0, rx_char_is_flow = 0, rx_fifo_err_present = 0;
logic thr_loaded = 0, thr_to_tsr = 0, tsr_busy = 0;
logic serial_in, cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin, interrupt_select_pin;
logic reg_rvalid, serial_out, rts_n, dtr_n, user_output_two_n, irq_out, irq_oe, rx_serial;
logic [3:0] modem_status_lines;
logic tx_resume, rx_char_store, fifo_ready_status_rd_en, loopback_active;
int err_count = 0, checks_done = 0, cyc = 0;
uart_modem_line_control u_uart_modem_line_control (.*);
uart_mlc_far u_uart_mlc_far (.int_sel(int_sel), .*);
always #50 clk_sys = ~clk_sys;
// a hang costs at most a few hundred microseconds
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        err_count++;
        end_of_test();
    end
end
task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
        err_count++;
        $display("unexpected %s: expected %h, seen %h", w, e, g);
    end
endtask
task automatic cb(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
endtask
task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_wr = 0;
    @(negedge clk_sys);
endtask
task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_rd = 0;
    cb("rvalid", 1'b1, reg_rvalid);
    chk("rdata", e, reg_rdata);
endtask
task automatic end_of_test();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
initial begin
    repeat (16) @(negedge clk_sys);
    resetn = 1;
    rd(3'h5, 8'h60);
    rd(3'h4, 8'h00);
    chk("status", 8'h00, {4'h0, modem_status_lines});
    wr(3'h4, 8'h0b);
    cb("rts", 1'b0, rts_n);
    cb("dtr", 1'b0, dtr_n);
    cb("out2", 1'b0, user_output_two_n);
    cb("irq_oe", 1'b1, irq_oe);
    wr(3'h4, 8'he3);
    rd(3'h4, 8'h03);
    enhanced_feature_en = 1;
    wr(3'h4, 8'he3);
    rd(3'h4, 8'he3);
    wr(3'h4, 8'h20);
    @(negedge clk_sys) {rx_char_valid, rx_char_is_flow, rx_sw_flow_en} = 3'b111;
    @(negedge clk_sys) cb("store", 1'b0, rx_char_store);
    cb("resume", 1'b1, tx_resume);
    rx_char_is_flow = 0;
    @(negedge clk_sys) cb("store", 1'b1, rx_char_store);
    rx_char_valid = 0;
    wr(3'h4, 8'h04);
    cb("fifo_rdy", 1'b1, fifo_ready_status_rd_en);
    auto_mode_status_bit0 = 1;
    @(negedge clk_sys) cb("fifo_rdy", 1'b0, fifo_ready_status_rd_en);
    auto_mode_status_bit0 = 0;
    wr(3'h4, 8'h1f);
    cb("serial_out", 1'b1, serial_out);
    cb("fifo_rdy", 1'b0, fifo_ready_status_rd_en);
    chk("status", 8'h0f, {4'h0, modem_status_lines});
    tx_serial = 0;
    @(negedge clk_sys) cb("rx_serial", 1'b0, rx_serial);
    tx_serial = 1;
    wr(3'h4, 8'h11);
    chk("status", 8'h02, {4'h0, modem_status_lines});
    wr(3'h4, 8'h00);
    {auto_rts_en, auto_rts_level} = 2'b11;
    repeat (2) @(negedge clk_sys);
    cb("rts", 1'b0, rts_n);
    auto_rts_en = 0;
    {thr_loaded, tsr_busy} = 2'b11;
    @(negedge clk_sys) thr_loaded = 0;
    rd(3'h5, 8'h00);
    thr_to_tsr = 1;
    @(negedge clk_sys) thr_to_tsr = 0;
    rd(3'h5, 8'h20);
    tsr_busy = 0;
    rd(3'h5, 8'h60);
    rx_fifo_err_present = 1;
    // level held long enough for the summary assertion to see it settle
    repeat (2) @(negedge clk_sys);
    rd(3'h5, 8'he0);
    rx_fifo_err_present = 0;
    rd(3'h5, 8'h60);
    line_control_dlab = 1;
    wr(3'h4, 8'h0f);
    rd(3'h5, 8'h00);
    line_control_dlab = 0;
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    cb("irq_oe", 1'b0, irq_oe);
    {int_sel, core_irq} = 2'b11;
    repeat (5) @(negedge clk_sys);
    cb("irq_oe", 1'b1, irq_oe);
    cb("irq_out", 1'b1, irq_out);
    end_of_test();
end
endmodule
